// ==== rtl/dir_ctrl_pkg.sv ====
// Shared constants for the line direction and echo control block
package dir_ctrl_pkg;
  // Transmit-to-receive changeover delay, in nanoseconds
  localparam int TURN_DELAY_NS = 10000;
  // Clock period in nanoseconds (10 MHz)
  localparam int CLOCK_PERIOD_NS = 100;
  // Changeover delay in cycles, rounded down as a longest time
  localparam int TURN_DELAY_CYCLES = TURN_DELAY_NS / CLOCK_PERIOD_NS;
  // Activity indicator stretch, in cycles, so a short bit stays visible
  localparam int ACTIVITY_HOLD_CYCLES = 1000;
  // Line idle (mark) level on data signals
  localparam logic MARK_LEVEL = 1'b1;
  // Reset values of the enables: driver off, receiver on
  localparam logic DRIVER_RESET = 1'b0;
  localparam logic RECEIVER_RESET = 1'b1;
  // Reset levels of handshakes, switches, half-duplex strap and indicator
  localparam logic HANDSHAKE_RESET = 1'b0;
  localparam logic SWITCH_RESET = 1'b0;
  localparam logic HALF_DUPLEX_N_RESET = 1'b1;
  localparam logic ACTIVITY_RESET = 1'b0;

  // Operating modes decoded from the switches
  typedef enum logic [2:0] {
    MODE_FOUR_WIRE,
    MODE_HS_ECHO,
    MODE_HS_NO_ECHO,
    MODE_AUTO_ECHO,
    MODE_AUTO_NO_ECHO
  } mode_t;
endpackage : dir_ctrl_pkg

// ==== rtl/input_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module input_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic pin_in,
  output logic level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // First stage feeds only the second; level moves once stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= RESET_LEVEL;
      s2_q <= RESET_LEVEL;
      s3_q <= RESET_LEVEL;
      level_q <= RESET_LEVEL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s2_q;
      end
    end
  end
endmodule : input_sync

// ==== rtl/rs485_direction_control.sv ====
// Direction and echo control between a host serial port and a line side
// Notes on behaviour
// RQ1: In four-wire master mode both data and handshake pass each way and all drivers and receivers stay on.
// RQ2: In handshake modes the line driver is on while host handshake is high and off while it is low.
// RQ3: In the echo modes the line receiver stays enabled at all times, even during transmit.
// RQ4: In the no-echo two-wire modes the receiver is off while the driver is on, and on otherwise.
// RQ5: In automatic mode the driver turns on by itself as soon as the host starts sending.
// RQ6: In automatic mode the driver returns to high impedance after the host transmission ends.
// RQ7: A low half-duplex control input on the current-loop port suppresses echo of sent data there.
// RQ8: An activity indicator shows data traffic in either direction.
// RQ9: The mode is decoded from the echo suppress, automatic and handshake switches; all off is four-wire.
// RQ10: Automatic changeover back to receive comes about ten microseconds after last activity, set at build time.
// RQ11: Each space level on host data restarts the changeover timer; the driver drops only at expiry.
`timescale 1ns/1ps
module rs485_direction_control #(
  parameter int TURN_CYCLES = dir_ctrl_pkg::TURN_DELAY_CYCLES,
  parameter int HOLD_CYCLES = dir_ctrl_pkg::ACTIVITY_HOLD_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic echo_suppress_switch,
  input wire logic auto_direction_switch,
  input wire logic handshake_direction_switch,
  input wire logic host_txd,
  input wire logic host_handshake,
  input wire logic line_rxd,
  input wire logic line_handshake,
  input wire logic current_loop_port_half_duplex_n,
  output logic line_txd,
  output logic line_handshake_out,
  output logic line_driver_en,
  output logic line_receiver_en,
  output logic host_rxd,
  output logic host_handshake_out,
  output logic loop_rxd,
  output logic activity_led
);
  import dir_ctrl_pkg::*;

  localparam int TW = $clog2(TURN_CYCLES + 1);
  localparam int HW = $clog2(HOLD_CYCLES + 1);

  logic txd_s;
  logic hs_s;
  logic rxd_s;
  logic lhs_s;
  logic hdx_n_s;
  logic no_echo_s;
  logic auto_s;
  logic hs_sw_s;
  logic auto_mode;
  logic [TW-1:0] turn_q;
  logic [TW-1:0] turn_d;
  logic [HW-1:0] hold_q;
  logic [HW-1:0] hold_d;
  logic drv_d;
  logic rcv_d;
  logic rxd_d;
  mode_t mode;

  // Every pin, switches included, is outside the clock domain
  localparam int PINS = 8;
  localparam logic [PINS-1:0] PIN_RESET = {SWITCH_RESET, SWITCH_RESET, SWITCH_RESET,
                                           HALF_DUPLEX_N_RESET, HANDSHAKE_RESET, MARK_LEVEL,
                                           HANDSHAKE_RESET, MARK_LEVEL};
  logic [PINS-1:0] pin_raw;
  logic [PINS-1:0] pin_s;
  assign pin_raw = {handshake_direction_switch, auto_direction_switch, echo_suppress_switch,
                    current_loop_port_half_duplex_n, line_handshake, line_rxd,
                    host_handshake, host_txd};

  // Switch bounce is filtered like data, so a switch pulse shorter than two samples never reaches the mode
  for (genvar i = 0; i < PINS; i++) begin : g_sync
    input_sync #(.RESET_LEVEL(PIN_RESET[i])) input_sync_inst (
      .clock(clock),
      .rst(rst),
      .pin_in(pin_raw[i]),
      .level_q(pin_s[i]));
  end

  // Filtered levels by name
  assign txd_s = pin_s[0];
  assign hs_s = pin_s[1];
  assign rxd_s = pin_s[2];
  assign lhs_s = pin_s[3];
  assign hdx_n_s = pin_s[4];
  assign no_echo_s = pin_s[5];
  assign auto_s = pin_s[6];
  assign hs_sw_s = pin_s[7];

  // Switch decode; handshake wins if both direction switches are set
  function automatic mode_t decode_mode(input logic no_echo, input logic auto_sw,
                                        input logic hs_sw);
    if (hs_sw) begin
      decode_mode = no_echo ? MODE_HS_NO_ECHO : MODE_HS_ECHO;
    end else if (auto_sw) begin
      decode_mode = no_echo ? MODE_AUTO_NO_ECHO : MODE_AUTO_ECHO;
    end else begin
      decode_mode = MODE_FOUR_WIRE;
    end
  endfunction : decode_mode

  assign mode = decode_mode(no_echo_s, auto_s, hs_sw_s); // RQ9
  assign auto_mode = (mode == MODE_AUTO_ECHO) || (mode == MODE_AUTO_NO_ECHO);

  // Changeover timer reloads on every space level of host data
  wire space_seen = (txd_s != MARK_LEVEL);
  assign turn_d = space_seen ? TW'(TURN_CYCLES) : // RQ11 RQ5
                  (turn_q != '0) ? turn_q - TW'(1) : turn_q; // RQ10

  // Activity stretch from either data direction
  wire traffic = space_seen || (rxd_s != MARK_LEVEL);
  assign hold_d = traffic ? HW'(HOLD_CYCLES) :
                  (hold_q != '0) ? hold_q - HW'(1) : hold_q; // RQ8

  // Driver and receiver enables by mode
  always_comb begin
    drv_d = DRIVER_RESET;
    rcv_d = RECEIVER_RESET;
    case (mode)
      MODE_FOUR_WIRE: begin
        drv_d = 1'b1; // RQ1
        rcv_d = 1'b1; // RQ1
      end
      MODE_HS_ECHO: begin
        drv_d = hs_s; // RQ2
        rcv_d = 1'b1; // RQ3
      end
      MODE_HS_NO_ECHO: begin
        drv_d = hs_s; // RQ2
        rcv_d = !hs_s; // RQ4
      end
      MODE_AUTO_ECHO: begin
        drv_d = space_seen || (turn_q != '0); // RQ5 RQ6
        rcv_d = 1'b1; // RQ3
      end
      MODE_AUTO_NO_ECHO: begin
        drv_d = space_seen || (turn_q != '0); // RQ5 RQ6
        rcv_d = !(space_seen || (turn_q != '0)); // RQ4
      end
      default: begin
        drv_d = DRIVER_RESET;
        rcv_d = RECEIVER_RESET;
      end
    endcase
  end

  // Receive data idles at mark while the receiver is off
  assign rxd_d = rcv_d ? rxd_s : MARK_LEVEL;

  // Timers and enables
  always_ff @(posedge clock) begin
    if (rst) begin
      turn_q <= '0;
      hold_q <= '0;
      line_driver_en <= DRIVER_RESET;
      line_receiver_en <= RECEIVER_RESET;
    end else begin
      turn_q <= turn_d;
      hold_q <= hold_d;
      line_driver_en <= drv_d;
      line_receiver_en <= rcv_d;
    end
  end

  // Data and handshake paths, all registered
  always_ff @(posedge clock) begin
    if (rst) begin
      line_txd <= MARK_LEVEL;
      host_rxd <= MARK_LEVEL;
      loop_rxd <= MARK_LEVEL;
      line_handshake_out <= HANDSHAKE_RESET;
      host_handshake_out <= HANDSHAKE_RESET;
      activity_led <= ACTIVITY_RESET;
    end else begin
      line_txd <= txd_s;
      host_rxd <= rxd_d;
      // Loop echo blocked while we drive, when half duplex is strapped low
      loop_rxd <= (!hdx_n_s && drv_d) ? MARK_LEVEL : rxd_d; // RQ7
      line_handshake_out <= (mode == MODE_FOUR_WIRE) ? hs_s : 1'b0; // RQ1
      host_handshake_out <= (mode == MODE_FOUR_WIRE) ? lhs_s : 1'b0; // RQ1
      activity_led <= (hold_d != '0); // RQ8
    end
  end

  // Checks
  AST_FOUR_WIRE_ON: assert property (@(posedge clock) disable iff (rst) // RQ1
    (mode == MODE_FOUR_WIRE) && $stable(mode) |=> line_driver_en && line_receiver_en)
    else $error("four-wire mode enables not both on");
  AST_HS_DRIVER: assert property (@(posedge clock) disable iff (rst) // RQ2
    (mode == MODE_HS_ECHO || mode == MODE_HS_NO_ECHO) |=> line_driver_en == $past(hs_s))
    else $error("driver does not follow handshake");
  AST_ECHO_RX_ON: assert property (@(posedge clock) disable iff (rst) // RQ3
    (mode == MODE_HS_ECHO || mode == MODE_AUTO_ECHO) |=> line_receiver_en)
    else $error("receiver off in echo mode");
  AST_NO_ECHO_EXCL: assert property (@(posedge clock) disable iff (rst) // RQ4
    (mode == MODE_HS_NO_ECHO || mode == MODE_AUTO_NO_ECHO) && $stable(mode)
    |=> line_receiver_en != line_driver_en)
    else $error("receiver and driver not exclusive");
  AST_AUTO_START: assert property (@(posedge clock) disable iff (rst) // RQ5
    auto_mode && space_seen |=> line_driver_en)
    else $error("driver not enabled on host data");
  AST_AUTO_RELEASE: assert property (@(posedge clock) disable iff (rst) // RQ6
    auto_mode && (turn_q == TW'(1)) && !space_seen ##1 auto_mode && !space_seen
    |=> !line_driver_en)
    else $error("driver not released after delay");
  AST_AUTO_HOLD: assert property (@(posedge clock) disable iff (rst) // RQ10
    auto_mode && (turn_q != '0) |=> line_driver_en)
    else $error("driver dropped before changeover delay");
  AST_HS_PASS: assert property (@(posedge clock) disable iff (rst) // RQ1
    (mode == MODE_FOUR_WIRE)
    |=> (line_handshake_out == $past(hs_s)) && (host_handshake_out == $past(lhs_s)))
    else $error("handshake not passed in four-wire mode");
  AST_HS_GATED: assert property (@(posedge clock) disable iff (rst) // RQ1
    (mode != MODE_FOUR_WIRE) |=> !line_handshake_out && !host_handshake_out)
    else $error("handshake passed outside four-wire mode");
  AST_RX_MARK: assert property (@(posedge clock) disable iff (rst) // RQ4
    !rcv_d |=> host_rxd == MARK_LEVEL)
    else $error("receive data not idle while receiver off");
  AST_TIMER_RELOAD: assert property (@(posedge clock) disable iff (rst) // RQ11
    space_seen |=> turn_q == TW'(TURN_CYCLES))
    else $error("changeover timer not reloaded");
  AST_LOOP_NO_ECHO: assert property (@(posedge clock) disable iff (rst) // RQ7
    !hdx_n_s && drv_d |=> loop_rxd == MARK_LEVEL)
    else $error("loop echo not suppressed");
  AST_ACTIVITY: assert property (@(posedge clock) disable iff (rst) // RQ8
    traffic |=> activity_led)
    else $error("activity indicator missed traffic");
  AST_LED_IDLE: assert property (@(posedge clock) disable iff (rst) // RQ8
    (hold_q == '0) && !traffic |=> !activity_led)
    else $error("activity indicator lit without traffic");

  COV_AUTO_TURN: cover property (@(posedge clock) disable iff (rst)
    (mode == MODE_AUTO_NO_ECHO) && line_driver_en ##1 !line_driver_en);
  COV_HS_TX: cover property (@(posedge clock) disable iff (rst)
    (mode == MODE_HS_NO_ECHO) && line_driver_en);
  COV_LOOP_BLOCK: cover property (@(posedge clock) disable iff (rst)
    !hdx_n_s && drv_d && !rxd_s);
  COV_AUTO_RESTART: cover property (@(posedge clock) disable iff (rst)
    auto_mode && !space_seen && (turn_q != '0) ##1 space_seen);
  COV_FOUR_WIRE_HS: cover property (@(posedge clock) disable iff (rst)
    (mode == MODE_FOUR_WIRE) && line_handshake_out);
endmodule : rs485_direction_control

// ==== tb/bus_node_model.sv ====
// Shared line model: what the block's receiver sees on the bus
`timescale 1ns/1ps
module bus_node_model (
  input wire logic line_txd,
  input wire logic line_driver_en,
  input wire logic peer_txd,
  output logic line_rxd
);
  // Own driver wins the bus; else the peer node, idle mark by termination
  assign line_rxd = line_driver_en ? line_txd : peer_txd;
endmodule : bus_node_model

// ==== tb/rs485_direction_control_bench.sv ====
// Self-checking bench for the direction and echo control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    $display("[FAIL] %s expected %b seen %b", nm, ex, got); \
    miscompares++; \
  end
module rs485_direction_control_bench;
  import dir_ctrl_pkg::*;
  localparam int TURN = 8;
  localparam int HOLD = 10;
  logic clock, rst, es, au, hsw, txd, hs, lhs, hdn, peer, t, h, l;
  wire logic rxd, ltxd, lhso, drv, rcv, hrxd, hhso, lrxd, led;
  int miscompares = 0;
  int cmp_count = 0;
  rs485_direction_control #(.TURN_CYCLES(TURN), .HOLD_CYCLES(HOLD)) rs485_direction_control_inst (
    .clock(clock), .rst(rst), .echo_suppress_switch(es), .auto_direction_switch(au),
    .handshake_direction_switch(hsw), .host_txd(txd), .host_handshake(hs),
    .line_rxd(rxd), .line_handshake(lhs), .current_loop_port_half_duplex_n(hdn),
    .line_txd(ltxd), .line_handshake_out(lhso), .line_driver_en(drv),
    .line_receiver_en(rcv), .host_rxd(hrxd), .host_handshake_out(hhso),
    .loop_rxd(lrxd), .activity_led(led));
  bus_node_model bus_node_model_inst (
    .line_txd(ltxd), .line_driver_en(drv), .peer_txd(peer), .line_rxd(rxd));
  // Expected driver enable; handshake switch wins over automatic
  function automatic logic exp_drv(logic a, logic s, logic hk, logic busy);
    return s ? hk : (a ? busy : 1'b1);
  endfunction : exp_drv
  // Receiver off only while driving in a no-echo mode
  function automatic logic exp_rcv(logic e, logic d);
    return !(e && d);
  endfunction : exp_rcv
  task automatic step(int n);
    repeat (n) @(negedge clock);
  endtask : step
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // Free-running 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Watchdog, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    print_verdict();
  end
  // Main sequence; inputs move on the falling edge only
  initial begin
    {es, au, hsw, hs, lhs} = 5'h00;
    {rst, txd, hdn, peer} = 4'hf;
    void'($urandom(32'h8635));
    step(20);
    rst = 1'b0;
    // Four-wire: random data and handshakes both ways, all enables on
    for (int i = 0; i < 16; i++) begin
      {t, h, l} = 3'($urandom);
      txd = t;
      hs = h;
      lhs = l;
      // Loop-back through the line takes two filter passes
      step(12);
      `CHK("line_txd", t, ltxd)
      `CHK("hs_out", h, lhso)
      `CHK("host_hs_out", l, hhso)
      `CHK("drv_4w", 1'b1, drv)
      `CHK("host_rxd", t, hrxd)
      `CHK("rcv_4w", 1'b1, rcv)
      `CHK("loop_rxd_4w", t, lrxd)
    end
    txd = 1'b1;
    $display("test four_wire done");
    // Handshake modes, echo and no echo, auto switch also set in the second
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 2; k++) begin
        es = 1'(m);
        au = 1'(m);
        hsw = 1'b1;
        hs = 1'(k);
        step(7);
        `CHK("drv_hs", exp_drv(au, 1'b1, hs, 1'b0), drv)
        `CHK("rcv_hs", exp_rcv(es, hs), rcv)
      end
    end
    hs = 1'b0;
    $display("test handshake done");
    // Automatic modes with timer restart, loop echo blocked while sending
    hsw = 1'b0;
    au = 1'b1;
    hdn = 1'b0;
    for (int m = 0; m < 2; m++) begin
      es = 1'(m);
      txd = 1'b0;
      // Long enough for the own echo to come back through the line
      step(12);
      `CHK("drv_auto_on", 1'b1, drv)
      `CHK("rcv_auto_on", exp_rcv(es, 1'b1), rcv)
      `CHK("loop_rxd", 1'b1, lrxd)
      `CHK("host_rxd_echo", es, hrxd)
      txd = 1'b1;
      step(5);
      txd = 1'b0;
      step(2);
      txd = 1'b1;
      step(9);
      `CHK("drv_restart", 1'b1, drv)
      `CHK("led_on", 1'b1, led)
      step(10);
      `CHK("drv_auto_off", 1'b0, drv)
      `CHK("rcv_auto_off", 1'b1, rcv)
      step(2 * HOLD);
      `CHK("led_idle", 1'b0, led)
      peer = 1'b0;
      step(7);
      `CHK("host_rxd_peer", 1'b0, hrxd)
      `CHK("led_rx", 1'b1, led)
      peer = 1'b1;
      step(2 * HOLD);
    end
    $display("test automatic done");
    print_verdict();
  end
endmodule : rs485_direction_control_bench
